// ==== core/rtc_century_flags.sv ====
// Purpose: century count, flags and hold/commit control of a clock slice
// Assumes: events arrive as one-cycle pulses synchronous to REF_CLK_IN
// Notes:   one-cycle ack on every access, unmapped addresses read zero
// Summary of operation
// - low century digit counts bcd 0 to 9
// - high century digit bcd, range 0 to 9
// - hold bit freezes counters, enables register writes
// - clearing hold loads changed time into counters
// - hold bit is zero after power up
// - seconds alarm compared only when ignore bit zero
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rtc_century_flags #(
  parameter int unsigned TICK_CYCLES = rtc_century_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                     REF_CLK_IN,
  input  wire logic                     RSTN_IN,
  // wishbone slave
  input  wire rtc_century_pkg::wb_req_s WB_REQ_IN,
  output var  rtc_century_pkg::wb_rsp_s WB_RSP_OUT,
  // status events
  input  wire logic                     WDOG_EVT_IN,
  input  wire logic                     PFAIL_EVT_IN,
  input  wire logic                     OSC_FAIL_EVT_IN,
  // year rollover from the calendar: advances the century
  input  wire logic                     CENT_CARRY_IN,
  // status outputs
  output logic                          CAL_OUT,
  output logic                          HOLD_OUT
);
  import rtc_century_pkg::*;

  // registers
  logic [7:0]  flags_reg;       // wdf af pf oscf 0 cal hold frz
  logic [7:0]  century_reg;     // visible century register
  logic [7:0]  cent_cnt_reg;    // running century counter
  logic [7:0]  alarm_reg;       // ignore bit and bcd alarm seconds
  logic [7:0]  seconds_reg;     // visible seconds register
  logic [7:0]  sec_cnt_reg;     // running seconds counter
  logic        changed_reg;     // software wrote time while held
  logic        ack_reg;         // bus answer
  logic [31:0] rdat_reg;        // read data
  logic [31:0] tick_reg;        // one-second divider

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] != BCD_MAX) begin
      return {v[7:4], v[3:0] + 4'h1};
    end else if (v[7:4] != BCD_MAX) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return 8'h00;
  endfunction : bcd_inc

  // bus decode
  wire        access  = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~ack_reg;
  wire        wr_lane = access & WB_REQ_IN.we & WB_REQ_IN.sel[0];
  wire        hold    = flags_reg[HOLD_BIT];
  wire        hit_flg = WB_REQ_IN.adr == FLAGS_OFS;
  wire        hit_cen = WB_REQ_IN.adr == CENTURY_OFS;
  wire        hit_alm = WB_REQ_IN.adr == ALARM_S_OFS;
  wire        hit_sec = WB_REQ_IN.adr == SECONDS_OFS;
  wire        wr_ok   = wr_lane & hold;
  wire [7:0]  wd      = WB_REQ_IN.dat[7:0];
  wire        rd_flg  = access & ~WB_REQ_IN.we & hit_flg;
  wire        tick    = tick_reg == TICK_CYCLES - 1;
  wire        commit  = wr_lane & hit_flg & hold & ~wd[HOLD_BIT];
  wire        sec_wrap = sec_cnt_reg == 8'h59;
  // alarm match with seconds ignore
  wire        alarm_hit = tick & ~hold & ~alarm_reg[IGN_BIT] &
                          (bcd_inc(sec_cnt_reg) == {1'b0, alarm_reg[6:0]}) &
                          ~sec_wrap;
  wire        alarm_wrap = tick & ~hold & ~alarm_reg[IGN_BIT] &
                           sec_wrap & (alarm_reg[6:0] == 7'h00);
  wire        af_set  = alarm_hit | alarm_wrap;

  // read data mux
  wire [7:0]  rd_byte = hit_flg ? flags_reg :
                        hit_cen ? century_reg :
                        hit_alm ? alarm_reg :
                        hit_sec ? seconds_reg : 8'h00;

  // one-second divider, cleared to zero while held
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tick_reg <= 32'h0000_0000;
    end else if (hold || tick) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  // bus answer, one cycle per access
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= access;
      rdat_reg <= {24'h00_0000, rd_byte};
    end
  end

  // flags: sticky events win over clears
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      flags_reg <= FLAGS_RST;
    end else begin
      if (rd_flg) begin
        flags_reg[WDF_BIT] <= 1'b0;
        flags_reg[AF_BIT]  <= 1'b0;
        flags_reg[PF_BIT]  <= 1'b0;
      end
      if (wr_lane && hit_flg) begin
        flags_reg[HOLD_BIT] <= wd[HOLD_BIT];
        flags_reg[FRZ_BIT]  <= wd[FRZ_BIT];
        if (hold) begin
          flags_reg[CAL_BIT] <= wd[CAL_BIT];
          if (!wd[OSCF_BIT]) begin
            flags_reg[OSCF_BIT] <= 1'b0;
          end
        end
      end
      // events set last so they win
      if (WDOG_EVT_IN) begin
        flags_reg[WDF_BIT] <= 1'b1;
      end
      if (af_set) begin
        flags_reg[AF_BIT] <= 1'b1;
      end
      if (PFAIL_EVT_IN) begin
        flags_reg[PF_BIT] <= 1'b1;
      end
      if (OSC_FAIL_EVT_IN) begin
        flags_reg[OSCF_BIT] <= 1'b1;
      end
    end
  end

  // hold comes out of reset cleared
  hold_reset_a: assert property (
    @(posedge REF_CLK_IN) $rose(RSTN_IN) |-> !hold)
    else $error("hold set after reset");
  // a flags read drops the wdf, af and pf event bits
  flag_clear_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (rd_flg && !WDOG_EVT_IN && !af_set && !PFAIL_EVT_IN)
      |=> flags_reg[7:5] == 3'b000)
    else $error("flags kept after read");
  // no alarm flag may appear while the seconds are ignored
  alarm_ignore_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (alarm_reg[IGN_BIT] && !flags_reg[AF_BIT]) |=> !flags_reg[AF_BIT])
    else $error("ignored alarm fired");

  // alarm register, writable only while held
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      alarm_reg <= ALARM_RST;
    end else if (wr_ok && hit_alm) begin
      alarm_reg <= wd;
    end
  end

  // visible time registers and change tracking
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      century_reg <= CENTURY_RST;
      seconds_reg <= SECONDS_RST;
      changed_reg <= 1'b0;
    end else if (wr_ok && hit_cen) begin
      century_reg <= wd;
      changed_reg <= 1'b1;
    end else if (wr_ok && hit_sec) begin
      seconds_reg <= wd;
      changed_reg <= 1'b1;
    end else if (commit) begin
      changed_reg <= 1'b0;
    end else if (!hold) begin
      century_reg <= cent_cnt_reg;
      seconds_reg <= sec_cnt_reg;
    end
  end

  // century write refused without hold
  blocked_write_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (wr_lane && hit_cen && !hold)
      |=> $stable(century_reg) || !$past(hold, 1)
      && century_reg == $past(cent_cnt_reg))
    else $error("write taken without hold");

  // running counters: frozen while held, loaded on commit
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cent_cnt_reg <= CENTURY_RST;
      sec_cnt_reg  <= SECONDS_RST;
    end else if (commit && changed_reg) begin
      cent_cnt_reg <= century_reg;
      sec_cnt_reg  <= seconds_reg;
    end else if (!hold) begin
      if (tick) begin
        sec_cnt_reg <= sec_wrap ? 8'h00 : bcd_inc(sec_cnt_reg);
      end
      if (CENT_CARRY_IN) begin
        cent_cnt_reg <= bcd_inc(cent_cnt_reg);
      end
    end
  end

  // century low digit never leaves bcd
  bcd_low_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    cent_cnt_reg[3:0] <= BCD_MAX)
    else $error("century low digit not bcd");
  // ninety-nine rolls over to zero
  bcd_high_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (cent_cnt_reg == 8'h99 && CENT_CARRY_IN && !hold && !commit)
      |=> cent_cnt_reg == 8'h00)
    else $error("century did not wrap");
  // seconds counter frozen while held
  hold_freeze_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (hold && !commit) |=> $stable(sec_cnt_reg))
    else $error("counter moved while held");
  // commit loads the written base time
  commit_load_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (commit && changed_reg) |=> cent_cnt_reg == $past(century_reg)
      && sec_cnt_reg == $past(seconds_reg))
    else $error("base time not loaded");

  // outputs
  assign WB_RSP_OUT = '{ack: ack_reg, dat: rdat_reg};
  assign CAL_OUT    = flags_reg[CAL_BIT];
  assign HOLD_OUT   = hold;
endmodule : rtc_century_flags
`default_nettype wire

// ==== core/rtc_century_pkg.sv ====
// Purpose: shared constants and carriers for the century and flags slice
// Assumes: classic wishbone, 32-bit data, byte registers in the low lane
// Notes:   offsets are byte addresses, one aligned word per register
`default_nettype none
package rtc_century_pkg;
  // register byte offsets
  localparam logic [19:0] FLAGS_OFS    = 20'h1_fff0;
  localparam logic [19:0] CENTURY_OFS  = 20'h1_fff4;
  localparam logic [19:0] ALARM_S_OFS  = 20'h1_fff8;
  localparam logic [19:0] SECONDS_OFS  = 20'h1_fffc;
  // flags field positions
  localparam int WDF_BIT  = 7;
  localparam int AF_BIT   = 6;
  localparam int PF_BIT   = 5;
  localparam int OSCF_BIT = 4;
  localparam int CAL_BIT  = 2;
  localparam int HOLD_BIT = 1;
  localparam int FRZ_BIT  = 0;
  // alarm seconds ignore bit
  localparam int IGN_BIT  = 7;
  // reset values
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [7:0] CENTURY_RST = 8'h00;
  localparam logic [7:0] ALARM_RST   = 8'h80;
  localparam logic [7:0] SECONDS_RST = 8'h00;
  // bcd limits
  localparam logic [3:0] BCD_MAX     = 4'h9;
  // one-second tick from 250 MHz
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned TICK_CYC   = CLK_HZ;

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [19:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // wishbone answer carrier
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;
endpackage : rtc_century_pkg
`default_nettype wire

// ==== verification/rtc_century_flags_test.sv ====
// Purpose: register level tests of the century and flags slice
// Assumes: short tick of 8 cycles per second
// Notes:   events and carry share one pulse vector
`timescale 1ns/100ps
`default_nettype none
module rtc_century_flags_test;
  import rtc_century_pkg::*;
  logic       ref_clk;    // 250 MHz clock
  logic       rstn;       // active low reset
  logic [3:0] ev;         // carry, osc fail, power fail, watchdog
  wb_req_s    req;        // bus request
  wb_rsp_s    rsp;        // bus answer
  logic       cal, hold;  // status outputs
  logic [7:0] rd;         // last read byte
  int         error_cnt = 0;
  int         tests_run = 0;
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  rtc_century_flags #(.TICK_CYCLES(8)) DUT (
    .REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .WB_REQ_IN(req),
    .WB_RSP_OUT(rsp), .WDOG_EVT_IN(ev[0]), .PFAIL_EVT_IN(ev[1]),
    .OSC_FAIL_EVT_IN(ev[2]), .CENT_CARRY_IN(ev[3]), .CAL_OUT(cal),
    .HOLD_OUT(hold));
  wb_host_model host (.clk_in(ref_clk), .rsp_in(rsp), .req_out(req));
  // compare and count
  task automatic check(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [19:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, rd);
    check(rd, e);
  endtask : rdc
  // one-cycle pulse on chosen event lines
  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    ev = 4'h0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(FLAGS_OFS, 8'h00);
    check({7'h00, hold}, 8'h00);
    wr(CENTURY_OFS, 8'h42);
    rdc(CENTURY_OFS, 8'h00);
    rdc(20'h0_0000, 8'h00);
    wr(FLAGS_OFS, 8'h06);
    check({6'h00, cal, hold}, 8'h01);
    wr(FLAGS_OFS, 8'h06);
    check({6'h00, cal, hold}, 8'h03);
    wr(CENTURY_OFS, 8'h19);
    pulse(4'h8);
    rdc(CENTURY_OFS, 8'h19);
    wr(FLAGS_OFS, 8'h00);
    pulse(4'h8);
    rdc(CENTURY_OFS, 8'h20);
    wr(FLAGS_OFS, 8'h02);
    wr(CENTURY_OFS, 8'h98);
    wr(FLAGS_OFS, 8'h00);
    pulse(4'h8);
    rdc(CENTURY_OFS, 8'h99);
    pulse(4'h8);
    rdc(CENTURY_OFS, 8'h00);
    // alarm on second six, then with the ignore bit set
    wr(FLAGS_OFS, 8'h02);
    wr(SECONDS_OFS, 8'h05);
    rdc(SECONDS_OFS, 8'h05);
    wr(ALARM_S_OFS, 8'h06);
    rdc(ALARM_S_OFS, 8'h06);
    wr(FLAGS_OFS, 8'h00);
    repeat (40) @(posedge ref_clk);
    rdc(FLAGS_OFS, 8'h40);
    rdc(FLAGS_OFS, 8'h00);
    wr(FLAGS_OFS, 8'h02);
    wr(ALARM_S_OFS, 8'h86);
    wr(FLAGS_OFS, 8'h00);
    repeat (600) @(posedge ref_clk);
    rdc(FLAGS_OFS, 8'h00);
    pulse(4'h7);
    rdc(FLAGS_OFS, 8'hb0);
    rdc(FLAGS_OFS, 8'h10);
    // oscillator fail bit clears only by a write while held
    wr(FLAGS_OFS, 8'h02);
    rdc(FLAGS_OFS, 8'h12);
    wr(FLAGS_OFS, 8'h02);
    rdc(FLAGS_OFS, 8'h02);
    wr(FLAGS_OFS, 8'h00);
    conclude();
  end
endmodule : rtc_century_flags_test
`default_nettype wire

// ==== verification/wb_host_model.sv ====
// Purpose: wishbone host stand-in for the century and flags slice
// Assumes: classic single cycles, byte data in lane zero
// Notes:   waits for ack unbounded here, the bench watchdog cuts hangs
`timescale 1ns/100ps
`default_nettype none
module wb_host_model (
  // clock
  input  wire logic                     clk_in,
  // bus
  input  wire rtc_century_pkg::wb_rsp_s rsp_in,
  output var  rtc_century_pkg::wb_req_s req_out
);
  import rtc_century_pkg::*;
  // bus idle from time zero
  initial req_out = '0;
  // one classic cycle, held until ack is seen at an edge
  task automatic xfer(input logic we, input logic [19:0] adr,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_in);
    req_out <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                 dat: {24'h00_0000, wd}};
    do @(posedge clk_in); while (rsp_in.ack !== 1'b1);
    rd = rsp_in.dat[7:0];
    req_out <= '0;
  endtask : xfer
endmodule : wb_host_model
`default_nettype wire
